//--- tcu_map.svh
// Encodings and reset values for the timer output compare unit
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH
`define TCU_CMP_RESET      16'h0000
`define TCU_STATE_RESET    1'b0
`define TCU_ACT_NONE       2'h0
`define TCU_ACT_TOGGLE     2'h1
`define TCU_ACT_CLEAR      2'h2
`define TCU_ACT_SET        2'h3
`define TCU_MODE_NORMAL    4'h0
`define TCU_MODE_CTC_CMP   4'h4
`define TCU_MODE_CTC_CAP   4'hC
`define TCU_MODE_FAST_LO   4'h5
`define TCU_MODE_FAST_HI   4'h7
`define TCU_MODE_FAST_CAP  4'hE
`define TCU_MODE_FAST_CMP  4'hF
`define TCU_MODE_RSVD      4'hD
`define TCU_SEL_HIGH       1'b1
`define TCU_SEL_LOW        1'b0
`endif

//--- tcu_pkg.sv
// Types shared by the timer output compare unit
package tcu_pkg;
  // Byte write request for one channel's compare value
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       high;   // 1 selects high byte, 0 low byte
    logic [7:0] data;   // Byte written
  } tcu_wr_s;
  // Counter side indications
  typedef struct packed {
    logic [15:0] count;    // Running timer count
    logic        tick;     // Timer clock enable pulse
    logic        top;      // Count at top
    logic        bottom;   // Count at zero
    logic        cnt_wr;   // CPU wrote the count this cycle
    logic        down;     // Counting down
  } tcu_cnt_s;
  // Per-channel state
  typedef struct packed {
    logic [15:0] cmp;      // Active compare value
    logic [15:0] buf_val;  // Buffered compare value
    logic        flag;     // Match flag
    logic        state;    // Output compare state
    logic        pend;     // Match seen, flag due at next tick
  } tcu_ch_s;
  // Waveform family of the selected mode
  typedef enum logic [1:0] {
    TCU_WAVE_NONPWM = 2'b00,
    TCU_WAVE_FAST   = 2'b01,
    TCU_WAVE_PHASE  = 2'b10
  } tcu_wave_e;
endpackage : tcu_pkg

//--- tcu_channel.sv
// One output compare channel: compare value, buffer, flag and output state
`timescale 1ns/1ns
`default_nettype none
`include "tcu_map.svh"
module tcu_channel (
  input  wire logic              clk,        // System clock
  input  wire logic              rst_n,      // Synchronous reset, active low
  input  wire tcu_pkg::tcu_cnt_s cnt,        // Counter indications
  input  wire logic              blocked,    // Matches suppressed this tick
  input  wire tcu_pkg::tcu_wave_e wave,      // Waveform family
  input  wire logic              buffered,   // Double buffering on
  input  wire tcu_pkg::tcu_wr_s  wr,         // Low or high byte write, high loads latch
  input  wire logic [7:0]        high_latch, // Shared high-byte latch
  input  wire logic [1:0]        action,     // Compare output action
  input  wire logic              irq_en,     // Compare interrupt enable
  input  wire logic              irq_ack,    // Interrupt executed
  input  wire logic              flag_clr,   // Software writes one to flag
  input  wire logic              force_cmp,  // Force compare strobe
  output tcu_pkg::tcu_ch_s       ch,         // Registered channel state
  output logic                   irq         // Interrupt request, registered
);
  tcu_pkg::tcu_ch_s next_ch;  // Next channel state
  logic             next_irq; // Next request
  logic             match;    // Raw equality
  logic             hit;      // Match that counts

  // Apply the action to the output state for a match or force
  function automatic logic apply_action(input logic cur, input logic [1:0] act,
                                        input tcu_pkg::tcu_wave_e w,
                                        input logic dn);
    logic res;
    res = cur;
    case (act)
      `TCU_ACT_NONE:   res = cur;                       // [R21]
      `TCU_ACT_TOGGLE: res = (w == tcu_pkg::TCU_WAVE_NONPWM) ? ~cur : cur;
      `TCU_ACT_CLEAR:  res = (w == tcu_pkg::TCU_WAVE_PHASE) ? dn : 1'b0;
      `TCU_ACT_SET:    res = (w == tcu_pkg::TCU_WAVE_PHASE) ? ~dn : 1'b1;
      default:         res = cur;
    endcase
    return res;
  endfunction

  // Comparator and next-state logic
  always_comb begin
    next_ch  = ch;
    match    = (cnt.count == ch.cmp);                   // [R1]
    hit      = match && cnt.tick && !blocked;           // [R14]
    // Flag one tick after the equality
    if (cnt.tick) begin
      next_ch.pend = hit;                               // [R2]
      if (ch.pend) begin
        next_ch.flag = 1'b1;                            // [R2]
      end
    end
    // Clears lose to a set in the same cycle
    if ((flag_clr || (irq_ack && irq_en)) && !(cnt.tick && ch.pend)) begin
      next_ch.flag = 1'b0;                              // [R3] [R4]
    end
    // Output state from matches; action read live
    if (hit) begin
      next_ch.state = apply_action(ch.state, action, wave, cnt.down); // [R5] [R17] [R18]
    end else if (cnt.tick && cnt.bottom && wave == tcu_pkg::TCU_WAVE_FAST
                 && action[1]) begin
      next_ch.state = ~action[0];                       // [R6]
    end
    if (force_cmp && wave == tcu_pkg::TCU_WAVE_NONPWM) begin
      next_ch.state = apply_action(ch.state, action, wave, 1'b0); // [R13] [R18]
    end
    // CPU writes: low byte commits latch plus byte
    if (wr.wr && wr.high == `TCU_SEL_LOW) begin
      if (buffered) begin
        next_ch.buf_val = {high_latch, wr.data};        // [R10] [R12]
      end else begin
        next_ch.cmp     = {high_latch, wr.data};        // [R8] [R10] [R11]
        next_ch.buf_val = {high_latch, wr.data};
      end
    end
    // Buffered value moves at top or bottom only
    if (buffered && cnt.tick &&
        ((wave == tcu_pkg::TCU_WAVE_FAST && cnt.bottom) ||
         (wave == tcu_pkg::TCU_WAVE_PHASE && cnt.top))) begin
      next_ch.cmp = ch.buf_val;                         // [R9]
    end
    next_irq = next_ch.flag && irq_en;                  // [R3]
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch.cmp     <= `TCU_CMP_RESET;
      ch.buf_val <= `TCU_CMP_RESET;
      ch.flag    <= 1'b0;
      ch.state   <= `TCU_STATE_RESET;                   // [R19]
      ch.pend    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      ch  <= next_ch;
      irq <= next_irq;
    end
  end

  a_flag_after_match: assert property (@(posedge clk) disable iff (!rst_n)
    cnt.tick && ch.pend |=> ch.flag)                    // [R2]
    else $error("flag not set one tick after match");
  a_force_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
    force_cmp && !ch.flag && !(cnt.tick && ch.pend) |=> !ch.flag) // [R13]
    else $error("force set the match flag");
  a_none_keeps_state: assert property (@(posedge clk) disable iff (!rst_n)
    action == `TCU_ACT_NONE && !(cnt.tick && cnt.bottom) |=> $stable(ch.state)) // [R21]
    else $error("state changed with no action");
  a_blocked_no_pend: assert property (@(posedge clk) disable iff (!rst_n)
    cnt.tick && blocked |=> !ch.pend)                   // [R14]
    else $error("blocked match was taken");
endmodule : tcu_channel
`default_nettype wire

//--- tcu_compare.sv
// Two-channel output compare unit of the 16-bit timer
`timescale 1ns/1ns
`default_nettype none
`include "tcu_map.svh"
// Notes on behaviour
// R1 - Compare full count with active value continuously
// R2 - Match flag set one timer tick later
// R3 - Enabled flag requests interrupt, ack clears it
// R4 - Writing one clears flag, zero ignored
// R5 - Output state follows match, mode, action
// R6 - Top and bottom handle extreme-value cases
// R7 - Channel A value may serve as top
// R8 - Buffered in PWM, direct otherwise
// R9 - Buffer moves to active at top/bottom
// R10 - CPU writes reach buffer or active register
// R11 - Only CPU changes value; high reads direct
// R12 - High byte latched, low write commits both
// R13 - Force strobe acts like match, no flag; code ignores it in PWM modes
// R14 - Count write blocks matches next tick
// R15 - Software avoids writing count to top/bottom
// R16 - Output state kept across mode change
// R17 - Action setting not buffered, used immediately
// R18 - New action applies at next match
// R19 - Reset clears output state to zero
// R20 - Nonzero action overrides port value, not direction
// R21 - Action zero leaves state unchanged
// R22 - Action has no effect on capture
// R23 - Counter supplies top and bottom indications
// R24 - Channels A and B independent, identical
module tcu_compare (
  input  wire logic              clk,              // System clock
  input  wire logic              rst_n,            // Synchronous reset, active low
  input  wire logic [15:0]       timer_count,      // Running count
  input  wire logic              timer_tick,       // Timer clock enable pulse
  input  wire logic              count_at_top,     // Counter at top
  input  wire logic              count_at_bottom,  // Counter at zero
  input  wire logic              count_down,       // Counting down
  input  wire logic              count_written,    // CPU wrote the count
  input  wire logic [3:0]        waveform_mode_sel,// Waveform mode
  input  wire logic [1:0]        wr_a,             // Channel A write: {high, low}
  input  wire logic [1:0]        wr_b,             // Channel B write: {high, low}
  input  wire logic [7:0]        wr_data,          // Write byte
  input  wire logic [1:0]        compare_output_action_a, // Action A
  input  wire logic [1:0]        compare_output_action_b, // Action B
  input  wire logic [1:0]        compare_irq_enable,      // {B, A}
  input  wire logic [1:0]        irq_ack,                 // {B, A}
  input  wire logic [1:0]        flag_clr_write,          // {B, A} written ones
  input  wire logic [1:0]        force_compare_strobe,    // {B, A}
  input  wire logic [1:0]        port_value,              // {B, A} general port
  input  wire logic [1:0]        output_pin_direction,    // {B, A}
  output logic [15:0]            compare_value_a,  // Read value A
  output logic [15:0]            compare_value_b,  // Read value B
  output logic [1:0]             compare_match_flag, // {B, A}
  output logic [1:0]             irq_req,          // {B, A}
  output logic [1:0]             compare_output_state, // {B, A}
  output logic [1:0]             pin_out,          // {B, A} pin value
  output logic [1:0]             pin_oe,           // {B, A} pin enable
  output logic [15:0]            top_value         // Channel A value as top
);
  // All unit-level state
  typedef struct packed {
    logic [7:0]  latch;   // Shared high-byte latch
    logic        blk;     // Count written, block next tick
    logic [1:0]  pout;    // Registered pin values
    logic [1:0]  poe;     // Registered pin enables
    logic [15:0] view_a;  // Registered read view of channel A
    logic [15:0] view_b;  // Registered read view of channel B
  } tcu_top_s;
  tcu_top_s         st;        // Current state
  tcu_top_s         next_st;   // Next state
  tcu_pkg::tcu_cnt_s cnt;      // Counter bundle
  tcu_pkg::tcu_wave_e wave;    // Waveform family
  logic             buffered;  // Double buffering active
  logic             blocked;   // Matches suppressed this tick
  tcu_pkg::tcu_ch_s ch_a;      // Channel A state
  tcu_pkg::tcu_ch_s ch_b;      // Channel B state
  tcu_pkg::tcu_wr_s w_a;       // Channel A write
  tcu_pkg::tcu_wr_s w_b;       // Channel B write
  logic [1:0]       irq_a_b;   // Channel requests

  // Classify mode into waveform family
  function automatic tcu_pkg::tcu_wave_e classify(input logic [3:0] m);
    tcu_pkg::tcu_wave_e r;
    r = tcu_pkg::TCU_WAVE_PHASE;
    case (m)
      `TCU_MODE_NORMAL, `TCU_MODE_CTC_CMP, `TCU_MODE_CTC_CAP, `TCU_MODE_RSVD:
        r = tcu_pkg::TCU_WAVE_NONPWM;
      4'h5, 4'h6, `TCU_MODE_FAST_HI, `TCU_MODE_FAST_CAP, `TCU_MODE_FAST_CMP:
        r = tcu_pkg::TCU_WAVE_FAST;
      default:
        r = tcu_pkg::TCU_WAVE_PHASE;
    endcase
    return r;
  endfunction

  // Read view: buffer while buffering is on, active value otherwise
  function automatic logic [15:0] read_view(input logic buf_on,
                                            input tcu_pkg::tcu_ch_s c);
    return buf_on ? c.buf_val : c.cmp;
  endfunction

  // Mode decode and counter bundle
  always_comb begin
    wave         = classify(waveform_mode_sel);
    buffered     = (wave != tcu_pkg::TCU_WAVE_NONPWM);     // [R8]
    cnt.count    = timer_count;
    cnt.tick     = timer_tick;
    cnt.top      = count_at_top;                           // [R23]
    cnt.bottom   = count_at_bottom;                        // [R23]
    cnt.cnt_wr   = count_written;
    cnt.down     = count_down;
    blocked      = st.blk || count_written;                // [R14]
    w_a.wr   = wr_a[0] || wr_a[1];
    w_a.high = wr_a[1];
    w_a.data = wr_data;
    w_b.wr   = wr_b[0] || wr_b[1];
    w_b.high = wr_b[1];
    w_b.data = wr_data;
  end

  // Channel A
  tcu_channel u_ch_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .cnt        (cnt),
    .blocked    (blocked),
    .wave       (wave),
    .buffered   (buffered),
    .wr         (w_a),
    .high_latch (st.latch),
    .action     (compare_output_action_a),
    .irq_en     (compare_irq_enable[0]),
    .irq_ack    (irq_ack[0]),
    .flag_clr   (flag_clr_write[0]),
    .force_cmp  (force_compare_strobe[0]),
    .ch         (ch_a),
    .irq        (irq_a_b[0])
  ); // [R24]

  // Channel B
  tcu_channel u_ch_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .cnt        (cnt),
    .blocked    (blocked),
    .wave       (wave),
    .buffered   (buffered),
    .wr         (w_b),
    .high_latch (st.latch),
    .action     (compare_output_action_b),
    .irq_en     (compare_irq_enable[1]),
    .irq_ack    (irq_ack[1]),
    .flag_clr   (flag_clr_write[1]),
    .force_cmp  (force_compare_strobe[1]),
    .ch         (ch_b),
    .irq        (irq_a_b[1])
  ); // [R24]

  // Latch, blocking and pin override
  always_comb begin
    next_st = st;
    // High byte write only loads the shared latch
    if ((wr_a[1] && !wr_a[0]) || (wr_b[1] && !wr_b[0])) begin
      next_st.latch = wr_data;                             // [R12]
    end
    // Count write holds block until the next tick passes
    if (count_written) begin
      next_st.blk = 1'b1;                                  // [R14]
    end else if (timer_tick) begin
      next_st.blk = 1'b0;
    end
    // Nonzero action selects compare state; direction stays with port
    next_st.pout[0] = (compare_output_action_a != `TCU_ACT_NONE)
                      ? ch_a.state : port_value[0];        // [R20] [R22]
    next_st.pout[1] = (compare_output_action_b != `TCU_ACT_NONE)
                      ? ch_b.state : port_value[1];        // [R20]
    next_st.poe     = output_pin_direction;                // [R20]
    // Read views are registered so the outputs come from flip-flops
    next_st.view_a  = read_view(buffered, ch_a);           // [R10] [R11]
    next_st.view_b  = read_view(buffered, ch_b);           // [R10] [R11]
  end

  // Unit state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.latch <= 8'h00;
      st.blk   <= 1'b0;
      st.pout  <= 2'b00;
      st.poe   <= 2'b00;
      st.view_a <= `TCU_CMP_RESET;
      st.view_b <= `TCU_CMP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs: channel state is registered inside each channel
  always_comb begin
    compare_value_a      = st.view_a;                      // [R10] [R11]
    compare_value_b      = st.view_b;                      // [R10] [R11]
    compare_match_flag   = {ch_b.flag, ch_a.flag};
    irq_req              = irq_a_b;
    compare_output_state = {ch_b.state, ch_a.state};       // [R16]
    pin_out              = st.pout;
    pin_oe               = st.poe;
    top_value            = ch_a.cmp;                       // [R7]
  end

  a_latch_commit: assert property (@(posedge clk) disable iff (!rst_n)
    wr_a == 2'b01 && !buffered && classify(waveform_mode_sel) == tcu_pkg::TCU_WAVE_NONPWM
    |=> ch_a.cmp == {$past(st.latch), $past(wr_data)})     // [R12]
    else $error("low byte write did not commit latch");
  a_direct_nonpwm: assert property (@(posedge clk) disable iff (!rst_n)
    !buffered && !wr_a[0] |=> $stable(ch_a.cmp) || $past(buffered)) // [R8]
    else $error("active value changed without a write");
  a_pin_override: assert property (@(posedge clk) disable iff (!rst_n)
    compare_output_action_a != `TCU_ACT_NONE |=> pin_out[0] == $past(ch_a.state)) // [R20]
    else $error("pin did not show compare state");
  a_pin_direction: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> pin_oe == $past(output_pin_direction))        // [R20]
    else $error("pin direction not from port");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    compare_match_flag[0] && compare_irq_enable[0] && $stable(compare_irq_enable[0])
    && !irq_ack[0] && !flag_clr_write[0] |=> irq_req[0])  // [R3]
    else $error("enabled flag gave no request");
endmodule : tcu_compare
`default_nettype wire

//--- tcu_counter_model.sv
// Behavioural counter and timer clock source that feeds the compare unit
`timescale 1ns/1ns
`default_nettype none
module tcu_counter_model #(
  parameter int          TICK_DIV = 2,        // System clocks per timer clock
  parameter logic [15:0] TOP_VAL  = 16'h000F  // Count at which the counter wraps
) (
  input  wire logic        clk,      // System clock
  input  wire logic        rst_n,    // Synchronous reset, active low
  input  wire logic        run,      // Timer clock enabled
  input  wire logic        load,     // Count write request, one cycle
  input  wire logic [15:0] load_val, // Value written to the count
  output logic [15:0]      count,    // Running count
  output logic             tick,     // Timer clock enable pulse
  output logic             top,      // Count at top
  output logic             bottom,   // Count at zero
  output logic             written   // Count was written, one cycle
);
  int div; // Divider toward the next tick
  // Count on each tick; a write overrides counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count   <= 16'h0000;
      tick    <= 1'b0;
      written <= 1'b0;
      div     <= 0;
    end else begin
      written <= load;
      tick    <= 1'b0;
      if (load) begin
        count <= load_val;
      end else if (run) begin
        // Tick generator
        if (div == TICK_DIV - 1) begin
          div  <= 0;
          tick <= 1'b1;
        end else begin
          div <= div + 1;
        end
        // Advance or wrap at top
        if (tick) begin
          count <= (count == TOP_VAL) ? 16'h0000 : count + 16'h0001;
        end
      end
    end
  end
  assign top    = (count == TOP_VAL);
  assign bottom = (count == 16'h0000);
endmodule // tcu_counter_model
`default_nettype wire

//--- test_tcu_compare.sv
// Self-checking testbench of the two-channel output compare unit
`timescale 1ns/1ns
`default_nettype none
`include "tcu_map.svh"
module test_tcu_compare;
  typedef struct packed {
    logic [1:0] act; // Action applied before the force strobe
    logic       st;  // State expected afterwards
  } tcu_row_s;
  logic        clk, rst_n, run, load;           // Clock, reset, counter control
  logic [15:0] load_val, count, cva, cvb, top_v; // Count and compare views
  logic        tick, top, bot, written, down;   // Counter indications and direction
  logic [3:0]  mode;                            // Waveform mode
  logic [1:0]  wr_a, wr_b, act_a, act_b;        // Byte writes and actions
  logic [7:0]  wr_data;                         // Write byte
  logic [1:0]  irq_en, ack, fclr, force_s;      // Interrupt and strobe inputs
  logic [1:0]  port_v, dir, flag, irq, st, pin, oe; // Port controls and results
  int          mismatches, n_checks, cycles;    // Counters
  tcu_row_s    rows [6];                        // Force table
  // Clock of 10 ns
  initial clk = 1'b0;
  always #5 clk = ~clk;
  tcu_counter_model u_cnt (.clk(clk), .rst_n(rst_n), .run(run), .load(load),
    .load_val(load_val), .count(count), .tick(tick), .top(top), .bottom(bot),
    .written(written));
  tcu_compare u_dut (.clk(clk), .rst_n(rst_n), .timer_count(count), .timer_tick(tick),
    .count_at_top(top), .count_at_bottom(bot), .count_down(down),
    .count_written(written), .waveform_mode_sel(mode), .wr_a(wr_a), .wr_b(wr_b),
    .wr_data(wr_data), .compare_output_action_a(act_a), .compare_output_action_b(act_b),
    .compare_irq_enable(irq_en), .irq_ack(ack), .flag_clr_write(fclr),
    .force_compare_strobe(force_s), .port_value(port_v), .output_pin_direction(dir),
    .compare_value_a(cva), .compare_value_b(cvb), .compare_match_flag(flag),
    .irq_req(irq), .compare_output_state(st), .pin_out(pin), .pin_oe(oe),
    .top_value(top_v));
  // Prints the counts and the verdict, then stops
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compares one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // High byte only loads the latch; the low byte commits both
  task automatic wr16(input bit b, input logic [15:0] v);
    if (b) wr_b = 2'b10; else wr_a = 2'b10;
    wr_data = v[15:8];
    cyc(1);
    if (b) wr_b = 2'b01; else wr_a = 2'b01;
    wr_data = v[7:0];
    cyc(1);
    wr_a = 2'b00;
    wr_b = 2'b00;
    cyc(1);
  endtask
  // Bounded wait for a match flag
  task automatic wait_flag(input int i, input int lim);
    int k;
    k = 0;
    while (flag[i] !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("timeout after %0d cycles", cycles);
      summarize();
    end
  end
  // Main sequence
  initial begin
    int k;
    logic keep;
    {rst_n, run, load, load_val, mode, wr_a, wr_b, wr_data} = '0;
    {act_a, act_b, irq_en, ack, fclr, force_s, down} = '0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    dir = 2'b11;
    port_v = 2'b10;
    rows = '{'{`TCU_ACT_SET, 1'b1}, '{`TCU_ACT_NONE, 1'b1}, '{`TCU_ACT_TOGGLE, 1'b0},
             '{`TCU_ACT_TOGGLE, 1'b1}, '{`TCU_ACT_CLEAR, 1'b0}, '{`TCU_ACT_NONE, 1'b0}};
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    chk("state", 16'h0000, {14'h0, st});
    chk("value a", `TCU_CMP_RESET, cva);
    chk("flag", 16'h0000, {14'h0, flag});
    $display("test reset done");
    // Force table in normal mode, channel B left at no action
    foreach (rows[i]) begin
      act_a = rows[i].act;
      force_s = 2'b01;
      cyc(1);
      force_s = 2'b00;
      cyc(3);
      chk("state a", {15'h0, rows[i].st}, {15'h0, st[0]});
      chk("flag", 16'h0000, {14'h0, flag});
      chk("pin a", {15'h0, (act_a != 2'h0) ? rows[i].st : port_v[0]}, {15'h0, pin[0]});
      chk("pins b", 16'h0001, {14'h0, st[1], pin[1]});
      chk("enables", 16'h0003, {14'h0, oe});
    end
    $display("test force done");
    // Direct writes and a timed match
    wr16(1'b0, 16'h0005);
    chk("value a", 16'h0005, cva);
    chk("top value", 16'h0005, top_v);
    wr16(1'b1, 16'h0009);
    chk("value b", 16'h0009, cvb);
    irq_en = 2'b01;
    run = 1'b1;
    k = 0;
    while (!(tick === 1'b1 && count === 16'h0005) && k < 100) begin
      cyc(1);
      k++;
    end
    cyc(1);
    chk("flag a early", 16'h0000, {15'h0, flag[0]});
    wait_flag(0, 8);
    chk("flag a", 16'h0001, {15'h0, flag[0]});
    chk("flag b", 16'h0000, {15'h0, flag[1]});
    cyc(2);
    chk("irq a", 16'h0001, {15'h0, irq[0]});
    ack = 2'b01;
    cyc(1);
    ack = 2'b00;
    cyc(2);
    chk("flag a acked", 16'h0000, {15'h0, flag[0]});
    wait_flag(1, 40);
    chk("flag b", 16'h0001, {15'h0, flag[1]});
    chk("irq b", 16'h0000, {15'h0, irq[1]});
    fclr = 2'b10;
    cyc(1);
    fclr = 2'b00;
    cyc(2);
    chk("flag b cleared", 16'h0000, {15'h0, flag[1]});
    $display("test match done");
    // Count write while stopped blocks the next match
    run = 1'b0;
    fclr = 2'b11;
    cyc(1);
    fclr = 2'b00;
    load_val = 16'h0005; // Not top, so no lost wrap
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    run = 1'b1;
    cyc(6);
    chk("flag blocked", 16'h0000, {15'h0, flag[0]});
    $display("test blocking done");
    // Buffered value in fast mode
    run = 1'b0;
    cyc(3);
    keep = st[0];
    mode = `TCU_MODE_FAST_LO;
    cyc(2);
    chk("state kept", {15'h0, keep}, {15'h0, st[0]});
    wr16(1'b0, 16'h0003);
    chk("buffer a", 16'h0003, cva);
    chk("active a", 16'h0005, top_v);
    act_a = `TCU_ACT_SET;
    force_s = 2'b01;
    cyc(1);
    force_s = 2'b00;
    cyc(3);
    chk("force ignored", {15'h0, keep}, {15'h0, st[0]});
    act_a = `TCU_ACT_CLEAR;
    run = 1'b1;
    k = 0;
    while (top_v !== 16'h0003 && k < 80) begin
      cyc(1);
      k++;
    end
    chk("active a", 16'h0003, top_v);
    chk("bottom set", 16'h0001, {15'h0, st[0]});
    $display("test buffer done");
    // Phase mode: clear action clears counting up, sets counting down
    mode = 4'h1;
    for (int d = 0; d <= 1; d++) begin
      down = d[0];
      k = 0;
      while (!(tick === 1'b1 && count === 16'h0003) && k < 40) begin
        cyc(1);
        k++;
      end
      cyc(2);
      chk("phase state", {15'h0, d[0]}, {15'h0, st[0]});
    end
    $display("test phase done");
    // Reset in mid-run after setting the state
    mode = `TCU_MODE_NORMAL;
    act_a = `TCU_ACT_SET;
    force_s = 2'b01;
    cyc(1);
    force_s = 2'b00;
    cyc(3);
    chk("state a set", 16'h0001, {15'h0, st[0]});
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk("state", 16'h0000, {14'h0, st});
    chk("value a", 16'h0000, cva);
    $display("test mid reset done");
    summarize();
  end
endmodule // test_tcu_compare
`default_nettype wire
